/* File: src/irq_vector_flags.sv */
// Interrupt flag, mask and vector logic with an AXI4-Lite register slave.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
module irq_vector_flags (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [7:0]               awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [7:0]               araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  input  wire irq_vector_pkg::sources_t sources,
  input  wire logic                     reset_pin,
  input  wire logic                     software_reset_trap,
  input  wire logic                     nmi_request,
  input  wire logic                     software_trap_valid,
  input  wire logic [4:0]               software_trap_number,
  input  wire logic                     take_ack,
  output logic                          offer_valid,
  output logic [6:0]                    offer_vector,
  output logic [4:0]                    offer_priority,
  output logic                          irq
);
  logic [15:0]                 flags_q, flags_d, mask_q, mask_d, hw_set, clr;
  logic [3:0]                  sel_q, sel_d;
  logic                        rst_pend_q, rst_pend_d, nmi_pend_q, nmi_pend_d;
  logic [13:0]                 soft_q, soft_d, soft_set, soft_clr;
  irq_vector_pkg::take_state_t state_q, state_d;
  irq_vector_pkg::kind_t       kind_q, kind_d, cand_kind;
  logic [3:0]                  idx_q, idx_d, cand_idx;
  logic                        offer_q, offer_d, cand_valid;
  logic [6:0]                  vec_q, vec_d, cand_vec;
  logic [4:0]                  pri_q, pri_d, cand_pri;
  logic                        irq_q, irq_d;
  logic                        aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0]                  waddr_q, waddr_d;
  logic [31:0]                 wdat_q, wdat_d, rdata_q, rdata_d;
  logic [3:0]                  wstb_q, wstb_d;
  logic                        awready_q, awready_d, wready_q, wready_d;
  logic                        bvalid_q, bvalid_d, arready_q, arready_d;
  logic                        rvalid_q, rvalid_d;
  logic [1:0]                  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [15:0]                 lane;
  logic [7:0]                  wa, ra;

  // Shared bits follow the DMA selection field.
  always_comb
  begin
    hw_set = '0;
    hw_set[irq_vector_pkg::BIT_EXT0] = sources.external_request_0;
    hw_set[irq_vector_pkg::BIT_EXT1] = sources.external_request_1;
    hw_set[irq_vector_pkg::BIT_EXT2] = sources.external_request_2;
    hw_set[irq_vector_pkg::BIT_TIMER0] = sources.timer0_request;
    hw_set[irq_vector_pkg::BIT_SER0_RX] = sources.serial0_receive_request;
    hw_set[irq_vector_pkg::BIT_SER0_TX] = sources.serial0_transmit_request;
    hw_set[irq_vector_pkg::BIT_DMA0] = sel_q[0] & sources.dma_ch0_request;
    hw_set[irq_vector_pkg::BIT_TIMER1] = sel_q[1] ? sources.dma_ch1_request
                                                  : sources.timer1_request;
    hw_set[irq_vector_pkg::BIT_EXT3] = sources.external_request_3;
    hw_set[irq_vector_pkg::BIT_HOST] = sources.host_port_request;
    // serial 1 receive or DMA 2
    hw_set[irq_vector_pkg::BIT_SER1_RX] =
      sel_q[2] ? sources.dma_ch2_request : sources.serial1_receive_request;
    // serial 1 transmit or DMA 3
    hw_set[irq_vector_pkg::BIT_SER1_TX] =
      sel_q[3] ? sources.dma_ch3_request : sources.serial1_transmit_request;
    hw_set[irq_vector_pkg::BIT_DMA4] = sources.dma_ch4_request;
    hw_set[irq_vector_pkg::BIT_DMA5] = sources.dma_ch5_request;
  end

  // Picks the source to offer next; later assignments win.
  always_comb
  begin
    cand_valid = 1'b0;
    cand_vec   = irq_vector_pkg::VEC_RESET;
    cand_pri   = irq_vector_pkg::PRI_NONE;
    cand_kind  = irq_vector_pkg::KIND_SOFT;
    cand_idx   = 4'h0;
    for (int i = irq_vector_pkg::SOFT_N - 1; i >= 0; i--)
    begin
      if (soft_q[i])
      begin
        cand_valid = 1'b1;
        cand_vec   = 7'(irq_vector_pkg::VEC_SOFT_FIRST
                        + 7'(i) * irq_vector_pkg::SLOT_STEP);
        cand_pri   = irq_vector_pkg::PRI_NONE;
        cand_kind  = irq_vector_pkg::KIND_SOFT;
        cand_idx   = 4'(i);
      end
    end
    for (int i = irq_vector_pkg::SRC_N - 1; i >= 0; i--)
    begin
      if (flags_q[i] && mask_q[i])
      begin
        cand_valid = 1'b1;
        cand_vec   = 7'(irq_vector_pkg::VEC_HW_BASE
                        + 7'(i) * irq_vector_pkg::SLOT_STEP);
        cand_pri   = 5'(irq_vector_pkg::PRI_HW_BASE + 5'(i));
        cand_kind  = irq_vector_pkg::KIND_HW;
        cand_idx   = 4'(i);
      end
    end
    if (nmi_pend_q)
    begin
      cand_valid = 1'b1;
      cand_vec   = irq_vector_pkg::VEC_NMI;
      cand_pri   = irq_vector_pkg::PRI_NMI;
      cand_kind  = irq_vector_pkg::KIND_NMI;
    end
    if (rst_pend_q)
    begin
      cand_valid = 1'b1;
      cand_vec   = irq_vector_pkg::VEC_RESET;
      cand_pri   = irq_vector_pkg::PRI_RESET;
      cand_kind  = irq_vector_pkg::KIND_RESET;
    end
  end

  // Next values of flags, offer handshake and register slave.
  always_comb
  begin
    wa = {waddr_q[7:2], 2'b00};
    ra = {araddr[7:2], 2'b00};
    lane = {{8{wstb_q[1]}}, {8{wstb_q[0]}}};
    clr = '0;
    soft_clr = '0;
    soft_set = '0;
    mask_d = mask_q;
    sel_d = sel_q;
    state_d = state_q;
    offer_d = offer_q;
    vec_d = vec_q;
    pri_d = pri_q;
    kind_d = kind_q;
    idx_d = idx_q;
    rst_pend_d = rst_pend_q;
    nmi_pend_d = nmi_pend_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    waddr_d = waddr_q;
    wdat_d = wdat_q;
    wstb_d = wstb_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (software_trap_valid
        && software_trap_number >= irq_vector_pkg::SOFT_FIRST_NUM
        && software_trap_number <= irq_vector_pkg::SOFT_LAST_NUM)
      soft_set[4'(software_trap_number - irq_vector_pkg::SOFT_FIRST_NUM)] = 1'b1;
    unique case (state_q)
      irq_vector_pkg::ST_IDLE:
        if (cand_valid)
        begin
          offer_d = 1'b1;
          vec_d = cand_vec;
          pri_d = cand_pri;
          kind_d = cand_kind;
          idx_d = cand_idx;
          state_d = irq_vector_pkg::ST_OFFER;
        end
      irq_vector_pkg::ST_OFFER:
        if (take_ack)
        begin
          offer_d = 1'b0;
          state_d = irq_vector_pkg::ST_IDLE;
          unique case (kind_q)
            irq_vector_pkg::KIND_RESET: rst_pend_d = 1'b0;
            irq_vector_pkg::KIND_NMI:   nmi_pend_d = 1'b0;
            irq_vector_pkg::KIND_HW:    clr[idx_q] = 1'b1;
            irq_vector_pkg::KIND_SOFT:  soft_clr[idx_q] = 1'b1;
          endcase
        end
      default: state_d = irq_vector_pkg::ST_IDLE;
    endcase
    if (awvalid && awready_q)
    begin
      aw_held_d = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready_q)
    begin
      w_held_d = 1'b1;
      wdat_d = wdata;
      wstb_d = wstrb;
    end
    if (aw_held_q && w_held_q && !bvalid_q)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = irq_vector_pkg::RESP_OKAY;
      if (wa == irq_vector_pkg::FLAGS_OFF)
        clr = clr | (wdat_q[15:0] & lane);
      else if (wa == irq_vector_pkg::MASK_OFF)
        mask_d = (mask_q & ~lane) | (wdat_q[15:0] & lane);
      else if (wa == irq_vector_pkg::DMA_SEL_OFF)
      begin
        if (wstb_q[0])
          sel_d = wdat_q[3:0];
      end
      else if (wa != irq_vector_pkg::OFFER_OFF)
        bresp_d = irq_vector_pkg::RESP_SLVERR;
    end
    if (arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = irq_vector_pkg::RESP_OKAY;
      rdata_d = '0;
      if (ra == irq_vector_pkg::FLAGS_OFF)
        rdata_d[15:0] = flags_q;
      else if (ra == irq_vector_pkg::MASK_OFF)
        rdata_d[15:0] = mask_q;
      else if (ra == irq_vector_pkg::DMA_SEL_OFF)
        rdata_d[3:0] = sel_q;
      else if (ra == irq_vector_pkg::OFFER_OFF)
        rdata_d[12:0] = {offer_q, pri_q, vec_q};
      else
        rresp_d = irq_vector_pkg::RESP_SLVERR;
    end
    // New requests win over any clear in the same cycle.
    flags_d = (flags_q & ~clr) | hw_set;
    flags_d = flags_d & ~irq_vector_pkg::RESERVED_BITS;
    mask_d = mask_d & ~irq_vector_pkg::RESERVED_BITS;
    soft_d = (soft_q & ~soft_clr) | soft_set;
    rst_pend_d = rst_pend_d | reset_pin | software_reset_trap;
    nmi_pend_d = nmi_pend_d | nmi_request;
    irq_d = |(flags_d & mask_d);
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_q <= irq_vector_pkg::FLAGS_RESET;
      mask_q <= irq_vector_pkg::MASK_RESET;
      sel_q <= irq_vector_pkg::DMA_SEL_RESET;
      rst_pend_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      soft_q <= '0;
      state_q <= irq_vector_pkg::ST_IDLE;
      offer_q <= 1'b0;
      vec_q <= irq_vector_pkg::VEC_RESET;
      pri_q <= irq_vector_pkg::PRI_NONE;
      kind_q <= irq_vector_pkg::KIND_RESET;
      idx_q <= 4'h0;
      irq_q <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 8'h00;
      wdat_q <= 32'h00000000;
      wstb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= irq_vector_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= irq_vector_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      flags_q <= flags_d;
      mask_q <= mask_d;
      sel_q <= sel_d;
      rst_pend_q <= rst_pend_d;
      nmi_pend_q <= nmi_pend_d;
      soft_q <= soft_d;
      state_q <= state_d;
      offer_q <= offer_d;
      vec_q <= vec_d;
      pri_q <= pri_d;
      kind_q <= kind_d;
      idx_q <= idx_d;
      irq_q <= irq_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wdat_q <= wdat_d;
      wstb_q <= wstb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign offer_valid = offer_q;
  assign offer_vector = vec_q;
  assign offer_priority = pri_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_taken;
    offer_q && take_ack;
  endsequence
  property p_reset_first;
    rst_pend_q && state_q == irq_vector_pkg::ST_IDLE
      |=> offer_q && vec_q == 7'h00 && pri_q == 5'h01;
  endproperty
  a_reset_first: assert property (p_reset_first)
    else $error("reset not offered at slot 00h priority 1");
  property p_nmi_slot;
    offer_q && kind_q == irq_vector_pkg::KIND_NMI
      |-> vec_q == 7'h04 && pri_q == 5'h02;
  endproperty
  a_nmi_slot: assert property (p_nmi_slot)
    else $error("nmi offer has wrong slot or priority");
  property p_hw_slot;
    offer_q && kind_q == irq_vector_pkg::KIND_HW
      |-> vec_q == 7'(7'h40 + 7'(idx_q) * 7'h04)
          && pri_q == 5'(5'h03 + 5'(idx_q));
  endproperty
  a_hw_slot: assert property (p_hw_slot)
    else $error("hardware offer slot or priority wrong");
  property p_hw_masked;
    $rose(offer_q) && kind_q == irq_vector_pkg::KIND_HW
      |-> |($past(flags_q & mask_q) & (16'h0001 << idx_q));
  endproperty
  a_hw_masked: assert property (p_hw_masked)
    else $error("hardware offer made without flag and mask both set");
  property p_soft_slot;
    offer_q && kind_q == irq_vector_pkg::KIND_SOFT
      |-> vec_q >= 7'h08 && vec_q <= 7'h3C && pri_q == 5'h00;
  endproperty
  a_soft_slot: assert property (p_soft_slot)
    else $error("software offer outside 08h to 3Ch");
  property p_take_clears;
    s_taken ##0 (kind_q == irq_vector_pkg::KIND_HW && !hw_set[idx_q])
      |=> !flags_q[$past(idx_q)] && !offer_q ##1 1'b1;
  endproperty
  a_take_clears: assert property (p_take_clears)
    else $error("taken flag not cleared or offer kept");
  property p_reserved;
    flags_q[15:14] == 2'b00 && mask_q[15:14] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved flag or mask bit set");
  property p_dma0_gate;
    $rose(flags_q[6]) |-> $past(sel_q[0] && sources.dma_ch0_request);
  endproperty
  a_dma0_gate: assert property (p_dma0_gate)
    else $error("bit 6 set without selected DMA 0 request");
  property p_timer1_share;
    $rose(flags_q[7]) |-> $past(sel_q[1] ? sources.dma_ch1_request
                                          : sources.timer1_request);
  endproperty
  a_timer1_share: assert property (p_timer1_share)
    else $error("bit 7 set by the unselected source");
endmodule // irq_vector_flags

/* File: src/irq_vector_pkg.sv */
// Constants and types shared by the interrupt vector and flag logic.
package irq_vector_pkg;
  localparam int unsigned AXI_ADDR_W     = 8;
  localparam int unsigned FLAG_W         = 16;
  localparam int unsigned SRC_N          = 14;
  localparam int unsigned SOFT_N         = 14;
  localparam int unsigned DMA_SEL_W      = 4;
  localparam logic [7:0]  FLAGS_OFF      = 8'h00;
  localparam logic [7:0]  MASK_OFF       = 8'h04;
  localparam logic [7:0]  DMA_SEL_OFF    = 8'h08;
  localparam logic [7:0]  OFFER_OFF      = 8'h0C;
  localparam logic [15:0] FLAGS_RESET    = 16'h0000;
  localparam logic [15:0] MASK_RESET     = 16'h0000;
  localparam logic [3:0]  DMA_SEL_RESET  = 4'h0;
  localparam logic [15:0] RESERVED_BITS  = 16'hC000;
  localparam int unsigned BIT_EXT0       = 0;
  localparam int unsigned BIT_EXT1       = 1;
  localparam int unsigned BIT_EXT2       = 2;
  localparam int unsigned BIT_TIMER0     = 3;
  localparam int unsigned BIT_SER0_RX    = 4;
  localparam int unsigned BIT_SER0_TX    = 5;
  localparam int unsigned BIT_DMA0       = 6;
  localparam int unsigned BIT_TIMER1     = 7;
  localparam int unsigned BIT_EXT3       = 8;
  localparam int unsigned BIT_HOST       = 9;
  localparam int unsigned BIT_SER1_RX    = 10;
  localparam int unsigned BIT_SER1_TX    = 11;
  localparam int unsigned BIT_DMA4       = 12;
  localparam int unsigned BIT_DMA5       = 13;
  localparam logic [6:0]  SLOT_STEP      = 7'h04;
  localparam logic [6:0]  VEC_RESET      = 7'h00;
  localparam logic [6:0]  VEC_NMI        = 7'h04;
  localparam logic [6:0]  VEC_SOFT_FIRST = 7'h08;
  localparam logic [6:0]  VEC_SOFT_LAST  = 7'h3C;
  localparam logic [6:0]  VEC_HW_BASE    = 7'h40;
  localparam logic [4:0]  PRI_NONE       = 5'h00;
  localparam logic [4:0]  PRI_RESET      = 5'h01;
  localparam logic [4:0]  PRI_NMI        = 5'h02;
  localparam logic [4:0]  PRI_HW_BASE    = 5'h03;
  localparam logic [4:0]  SOFT_FIRST_NUM = 5'h11;
  localparam logic [4:0]  SOFT_LAST_NUM  = 5'h1E;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {KIND_RESET, KIND_NMI, KIND_HW, KIND_SOFT} kind_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_OFFER = 2'b10} take_state_t;

  typedef struct packed {
    logic dma_ch5_request;
    logic dma_ch4_request;
    logic dma_ch3_request;
    logic dma_ch2_request;
    logic dma_ch1_request;
    logic dma_ch0_request;
    logic host_port_request;
    logic serial1_transmit_request;
    logic serial1_receive_request;
    logic serial0_transmit_request;
    logic serial0_receive_request;
    logic timer1_request;
    logic timer0_request;
    logic external_request_3;
    logic external_request_2;
    logic external_request_1;
    logic external_request_0;
  } sources_t;
endpackage

/* File: tb/core_take_model.sv */
// Behavioural model of the core sequencer that takes offered vectors.
module core_take_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       offer_valid,
  input  wire logic [6:0] offer_vector,
  input  wire logic [4:0] offer_priority,
  input  wire logic       hold,
  output logic            take_ack,
  output logic [6:0]      last_vector,
  output logic [4:0]      last_priority,
  output int              takes
);
  timeunit 1ns;
  timeprecision 100ps;

  // Takes each offer once with a one-cycle pulse unless the bench holds off.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      take_ack <= 1'b0;
      takes    <= 0;
    end
    else
    begin
      take_ack <= 1'b0;
      if (offer_valid && !take_ack && !hold)
      begin
        take_ack      <= 1'b1;
        last_vector   <= offer_vector;
        last_priority <= offer_priority;
        takes         <= takes + 1;
      end
    end
  end
endmodule // core_take_model

/* File: tb/dsp_interrupt_vector_flags_tb.sv */
// Self-checking testbench of the interrupt flag, mask and vector block.
module dsp_interrupt_vector_flags_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                     aclk, aresetn, awvalid, wvalid, bready;
  logic                     arvalid, rready, awready, wready, bvalid;
  logic                     arready, rvalid, offer_valid, irq, take_ack;
  logic                     reset_pin, software_reset_trap, nmi_request;
  logic                     software_trap_valid, hold;
  logic [4:0]               software_trap_number, offer_priority;
  logic [4:0]               last_priority;
  logic [6:0]               offer_vector, last_vector;
  logic [7:0]               awaddr, araddr;
  logic [31:0]              wdata, rdata;
  logic [3:0]               wstrb;
  logic [1:0]               bresp, rresp;
  irq_vector_pkg::sources_t sources;
  int                       takes, bad_count, compares;
  int                       src_def [14] = '{0, 1, 2, 4, 6, 7, -1, 5, 3, 10,
                                             8, 9, 15, 16};
  int                       src_dma [14] = '{0, 1, 2, 4, 6, 7, 11, 12, 3,
                                             10, 13, 14, 15, 16};

  irq_vector_flags dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sources(sources), .reset_pin(reset_pin),
    .software_reset_trap(software_reset_trap), .nmi_request(nmi_request),
    .software_trap_valid(software_trap_valid),
    .software_trap_number(software_trap_number), .take_ack(take_ack),
    .offer_valid(offer_valid), .offer_vector(offer_vector),
    .offer_priority(offer_priority), .irq(irq));

  core_take_model core (.aclk(aclk), .aresetn(aresetn),
    .offer_valid(offer_valid), .offer_vector(offer_vector),
    .offer_priority(offer_priority), .hold(hold), .take_ack(take_ack),
    .last_vector(last_vector), .last_priority(last_priority),
    .takes(takes));

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    check(rdata, ed);
    check(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask

  // Raises the given requests for exactly one cycle; m is reset, soft reset,
  // non-maskable.
  task automatic strobe(input logic [16:0] s, input logic [4:0] tn,
                        input logic [2:0] m);
    @(posedge aclk);
    sources              <= irq_vector_pkg::sources_t'(s);
    software_trap_valid  <= (tn != 5'h00);
    software_trap_number <= tn;
    {reset_pin, software_reset_trap, nmi_request} <= m;
    @(posedge aclk);
    sources              <= irq_vector_pkg::sources_t'(17'h00000);
    software_trap_valid  <= 1'b0;
    {reset_pin, software_reset_trap, nmi_request} <= 3'h0;
  endtask

  task automatic expect_take(input logic [6:0] v, input logic [4:0] p);
    int n;
    n = takes;
    repeat (20)
      if (takes == n)
        @(posedge aclk);
    check(32'(takes - n), 32'h00000001);
    check(32'(last_vector), 32'(v));
    check(32'(last_priority), 32'(p));
  endtask

  task automatic t_reset_values();
    rd(8'h00, 32'h00000000, irq_vector_pkg::RESP_OKAY);
    rd(8'h04, 32'h00000000, irq_vector_pkg::RESP_OKAY);
    rd(8'h08, 32'h00000000, irq_vector_pkg::RESP_OKAY);
    rd(8'h10, 32'h00000000, irq_vector_pkg::RESP_SLVERR);
    wr(8'h10, 32'h0000FFFF, irq_vector_pkg::RESP_SLVERR);
    wr(8'h0C, 32'h00001FFF, irq_vector_pkg::RESP_OKAY);
    rd(8'h0C, 32'h00000000, irq_vector_pkg::RESP_OKAY);
  endtask

  task automatic t_table(input logic [3:0] sel);
    int s;
    wr(8'h08, {28'h0000000, sel}, irq_vector_pkg::RESP_OKAY);
    wr(8'h04, 32'h00003FFF, irq_vector_pkg::RESP_OKAY);
    for (int b = 0; b < 14; b++)
    begin
      s = (sel != 4'h0) ? src_dma[b] : src_def[b];
      if (s >= 0)
      begin
        strobe(17'h00001 << s, 5'h00, 3'h0);
        expect_take(7'h40 + 7'(4 * b), 5'(3 + b));
        rd(8'h00, 32'h00000000, irq_vector_pkg::RESP_OKAY);
        check(32'(irq), 32'h00000000);
      end
    end
  endtask

  task automatic t_reserved();
    wr(8'h08, 32'h00000000, irq_vector_pkg::RESP_OKAY);
    wr(8'h04, 32'h0000FFFF, irq_vector_pkg::RESP_OKAY);
    rd(8'h04, 32'h00003FFF, irq_vector_pkg::RESP_OKAY);
    wstrb <= 4'h2;
    wr(8'h04, 32'h00000000, irq_vector_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd(8'h04, 32'h000000FF, irq_vector_pkg::RESP_OKAY);
    strobe(17'h00800, 5'h00, 3'h0);
    repeat (4) @(posedge aclk);
    check(32'(offer_valid), 32'h00000000);
    rd(8'h00, 32'h00000000, irq_vector_pkg::RESP_OKAY);
  endtask

  task automatic t_mask_clear();
    hold <= 1'b1;
    wr(8'h04, 32'h00000000, irq_vector_pkg::RESP_OKAY);
    strobe(17'h00008, 5'h00, 3'h0);
    rd(8'h00, 32'h00000100, irq_vector_pkg::RESP_OKAY);
    check(32'(irq), 32'h00000000);
    check(32'(offer_valid), 32'h00000000);
    wr(8'h00, 32'h00000100, irq_vector_pkg::RESP_OKAY);
    rd(8'h00, 32'h00000000, irq_vector_pkg::RESP_OKAY);
    strobe(17'h00008, 5'h00, 3'h0);
    wr(8'h04, 32'h00000100, irq_vector_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'(irq), 32'h00000001);
    rd(8'h0C, 32'h000015E0, irq_vector_pkg::RESP_OKAY);
    hold <= 1'b0;
    expect_take(7'h60, 5'h0B);
  endtask

  task automatic t_priority();
    hold <= 1'b1;
    wr(8'h04, 32'h00000005, irq_vector_pkg::RESP_OKAY);
    strobe(17'h00005, 5'h00, 3'h0);
    repeat (3) @(posedge aclk);
    hold <= 1'b0;
    expect_take(7'h40, 5'h03);
    expect_take(7'h48, 5'h05);
    hold <= 1'b1;
    wr(8'h04, 32'h00000000, irq_vector_pkg::RESP_OKAY);
    strobe(17'h00000, 5'h11, 3'h1);
    repeat (3) @(posedge aclk);
    hold <= 1'b0;
    expect_take(7'h04, 5'h02);
    expect_take(7'h08, 5'h00);
    strobe(17'h00000, 5'h00, 3'h4);
    expect_take(7'h00, 5'h01);
    strobe(17'h00000, 5'h00, 3'h2);
    expect_take(7'h00, 5'h01);
  endtask

  task automatic t_soft();
    int n0;
    for (int n = 17; n <= 30; n++)
    begin
      strobe(17'h00000, 5'(n), 3'h0);
      expect_take(7'h08 + 7'(4 * (n - 17)), 5'h00);
    end
    n0 = takes;
    strobe(17'h00000, 5'h1F, 3'h0);
    strobe(17'h00000, 5'h10, 3'h0);
    repeat (4) @(posedge aclk);
    check(32'(takes - n0), 32'h00000000);
  endtask

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, hold} = 7'h00;
    {reset_pin, software_reset_trap, nmi_request} = 3'h0;
    {software_trap_valid, software_trap_number} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0000000000000;
    wstrb = 4'hF;
    sources = irq_vector_pkg::sources_t'(17'h00000);
    bad_count = 0;
    compares = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_table(4'h0);
    t_table(4'hF);
    t_reserved();
    t_mask_clear();
    t_priority();
    t_soft();
    results();
  end

  initial
  begin
    repeat (8000) @(posedge aclk);
    bad_count++;
    results();
  end
endmodule // dsp_interrupt_vector_flags_tb
